//--- include/cmp_ctl_defs.svh
// register offsets, field positions and reset values of the comparator control block
`ifndef CMP_CTL_DEFS_SVH
`define CMP_CTL_DEFS_SVH
`define CMP_CONTROL_IDX     8'h1f
`define CMP_FLAG_IDX        8'h0c
`define CMP_ENABLE_IDX      8'h8c
`define CMP_IRQCTL_IDX      8'h0b
`define CMP_PORTA_IDX       8'h05
`define CMP_DIR_IDX         8'h85
`define CMP_CONTROL_RESET   8'h00
`define CMP_DIR_RESET       8'hff
`define CMP_CMP2_RESULT_BIT       7
`define CMP_CMP1_RESULT_BIT       6
`define CMP_CMP2_POLARITY_FLIP_BIT       5
`define CMP_CMP1_POLARITY_FLIP_BIT       4
`define CMP_CIS_BIT         3
`define CMP_FLAG_BIT        6
`define CMP_IE_BIT          6
`define CMP_PERIPHERAL_IRQ_ENABLE_BIT        6
`define CMP_GIE_BIT         7
`endif

//--- include/cmp_ctl_pkg.sv
// types of the comparator control block
package cmp_ctl_pkg;
  typedef enum logic [2:0] {
    mode_reset    = 3'h0,
    mode_one_ind  = 3'h1,
    mode_four_ref = 3'h2,
    mode_common   = 3'h3,
    mode_two_ind  = 3'h4,
    mode_one_more = 3'h5,
    mode_outputs  = 3'h6,
    mode_off      = 3'h7
  } mode_type;
endpackage : cmp_ctl_pkg

//--- hw/dual_comparator_control.sv
// comparator mode, polarity, change detect and port muxing behind wishbone
//
// Register access over Wishbone is this design's own decision.
`include "cmp_ctl_defs.svh"
module dual_comparator_control (
  // clock and reset
  input  wire  logic       clock,
  input  wire  logic       rst,
  // wishbone slave
  input  wire  logic       wb_cyc_i,
  input  wire  logic       wb_stb_i,
  input  wire  logic       wb_we_i,
  input  wire  logic [7:0] wb_adr_i,
  input  wire  logic [3:0] wb_sel_i,
  input  wire  logic [31:0] wb_dat_i,
  output logic       [31:0] wb_dat_o,
  output logic             wb_ack_o,
  output logic             wb_err_o,
  // analog front end
  input  wire  logic       cmp1_raw,
  input  wire  logic       cmp2_raw,
  output logic       [2:0] cmp_mode,
  output logic             cmp1_enable,
  output logic             cmp2_enable,
  output logic             cmp1_neg_sel_pin3,
  output logic             cmp2_neg_sel_pin2,
  output logic             ref_to_plus,
  // port a pins
  input  wire  logic [4:0] porta_pin_i,
  output logic       [4:0] porta_pin_o,
  output logic       [4:0] porta_pin_oe,
  // interrupt
  output logic             irq
);
  logic [7:0] control_reg;
  logic [7:0] dir_reg;
  logic [4:0] latch_reg;
  logic       flag_reg;
  logic       ie_reg;
  logic       peripheral_irq_enable_reg;
  logic       gie_reg;
  logic [1:0] snap_reg;
  logic [1:0] sync1_reg;
  logic [1:0] sync2_reg;
  logic [4:0] pin_s1_reg;
  logic [4:0] pin_s2_reg;
  logic       ack_reg;
  logic [31:0] rdata_reg;
  logic [1:0] live;
  logic [4:0] analog_mask;
  logic [7:0] rd_val;
  logic       access;
  logic       wr;
  logic       hit;
  logic       ctl_access;
  logic       wr_control;
  logic       wr_flag;
  logic       mismatch;
  cmp_ctl_pkg::mode_type mode;

  function automatic logic [4:0] analog_pins(input cmp_ctl_pkg::mode_type m);
    case (m)
      cmp_ctl_pkg::mode_one_ind:  analog_pins = 5'h0f;
      cmp_ctl_pkg::mode_two_ind:  analog_pins = 5'h0f;
      cmp_ctl_pkg::mode_outputs:  analog_pins = 5'h07;
      cmp_ctl_pkg::mode_common:   analog_pins = 5'h07;
      cmp_ctl_pkg::mode_one_more: analog_pins = 5'h03;
      cmp_ctl_pkg::mode_off:      analog_pins = 5'h00;
      default:                    analog_pins = 5'h0f;
    endcase
  endfunction : analog_pins

  // one for every index that has a register behind it
  function automatic logic known_index(input logic [7:0] a);
    case (a)
      `CMP_CONTROL_IDX, `CMP_FLAG_IDX, `CMP_ENABLE_IDX,
      `CMP_IRQCTL_IDX, `CMP_PORTA_IDX, `CMP_DIR_IDX: known_index = 1'b1;
      default:                                      known_index = 1'b0;
    endcase
  endfunction : known_index

  assign mode = cmp_ctl_pkg::mode_type'(control_reg[2:0]);
  assign cmp_mode = control_reg[2:0];
  assign cmp1_enable = !(mode inside {cmp_ctl_pkg::mode_reset, cmp_ctl_pkg::mode_off});
  assign cmp2_enable = cmp1_enable;
  assign cmp1_neg_sel_pin3 = control_reg[`CMP_CIS_BIT] &&
                             (mode inside {cmp_ctl_pkg::mode_one_ind,
                                           cmp_ctl_pkg::mode_four_ref});
  assign cmp2_neg_sel_pin2 = control_reg[`CMP_CIS_BIT] &&
                             (mode == cmp_ctl_pkg::mode_four_ref);
  assign ref_to_plus = (mode == cmp_ctl_pkg::mode_four_ref);
  assign live = {cmp2_raw ^ control_reg[`CMP_CMP2_POLARITY_FLIP_BIT],
                 cmp1_raw ^ control_reg[`CMP_CMP1_POLARITY_FLIP_BIT]};
  assign analog_mask = analog_pins(mode);

  // bus decode
  assign access = wb_cyc_i && wb_stb_i && !ack_reg;
  assign wr = access && wb_we_i && wb_sel_i[0];
  assign hit = known_index(wb_adr_i);
  assign ctl_access = access && wb_adr_i == `CMP_CONTROL_IDX;
  // write strobes
  assign wr_control = wr && wb_adr_i == `CMP_CONTROL_IDX;
  assign wr_flag = wr && wb_adr_i == `CMP_FLAG_IDX;
  assign wb_ack_o = ack_reg;
  assign wb_err_o = 1'b0;
  assign wb_dat_o = rdata_reg;

  always_comb begin
    rd_val = 8'h00;
    case (wb_adr_i)
      `CMP_CONTROL_IDX: rd_val = {sync2_reg, control_reg[5:0]};
      `CMP_FLAG_IDX:    rd_val = {1'b0, flag_reg, 6'h00};
      `CMP_ENABLE_IDX:  rd_val = {1'b0, ie_reg, 6'h00};
      `CMP_IRQCTL_IDX:  rd_val = {gie_reg, peripheral_irq_enable_reg, 6'h00};
      `CMP_PORTA_IDX:   rd_val = {3'h0, pin_s2_reg & ~analog_mask};
      `CMP_DIR_IDX:     rd_val = dir_reg;
      default:          rd_val = 8'h00;
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      ack_reg <= 1'b0;
      rdata_reg <= 32'h0;
    end else begin
      ack_reg <= access;
      rdata_reg <= (access && hit) ? {24'h0, rd_val} : 32'h0;
    end
  end

  // control register, result bits never written
  always_ff @(posedge clock) begin
    if (rst) begin
      control_reg <= `CMP_CONTROL_RESET;
    end else if (wr_control) begin
      control_reg <= {2'b00, wb_dat_i[5:0]};
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      dir_reg <= `CMP_DIR_RESET;
      latch_reg <= 5'h00;
      ie_reg <= 1'b0;
      peripheral_irq_enable_reg <= 1'b0;
      gie_reg <= 1'b0;
    end else if (wr) begin
      if (wb_adr_i == `CMP_DIR_IDX) dir_reg <= wb_dat_i[7:0];
      if (wb_adr_i == `CMP_PORTA_IDX) latch_reg <= wb_dat_i[4:0];
      if (wb_adr_i == `CMP_ENABLE_IDX) ie_reg <= wb_dat_i[`CMP_IE_BIT];
      if (wb_adr_i == `CMP_IRQCTL_IDX) begin
        peripheral_irq_enable_reg <= wb_dat_i[`CMP_PERIPHERAL_IRQ_ENABLE_BIT];
        gie_reg <= wb_dat_i[`CMP_GIE_BIT];
      end
    end
  end

  // synchronisers for comparator results and pins
  always_ff @(posedge clock) begin
    if (rst) begin
      sync1_reg <= 2'b00;
      sync2_reg <= 2'b00;
      pin_s1_reg <= 5'h00;
      pin_s2_reg <= 5'h00;
    end else begin
      sync1_reg <= live;
      sync2_reg <= sync1_reg;
      pin_s1_reg <= porta_pin_i;
      pin_s2_reg <= pin_s1_reg;
    end
  end

  // snapshot and change flag
  always_ff @(posedge clock) begin
    if (rst) begin
      snap_reg <= 2'b00;
    end else if (ctl_access) begin
      snap_reg <= sync2_reg;
    end
  end

  assign mismatch = sync2_reg != snap_reg;

  always_ff @(posedge clock) begin
    if (rst) begin
      flag_reg <= 1'b0;
    end else if (mismatch) begin
      flag_reg <= 1'b1;
    end else if (wr_flag) begin
      flag_reg <= wb_dat_i[`CMP_FLAG_BIT];
    end
  end

  assign irq = flag_reg && ie_reg && peripheral_irq_enable_reg && gie_reg;

  // pin drivers
  always_comb begin
    porta_pin_o = latch_reg;
    if (mode == cmp_ctl_pkg::mode_outputs) begin
      porta_pin_o[3] = live[0];
      porta_pin_o[4] = live[1];
    end
    porta_pin_oe = ~dir_reg[4:0] & ~analog_mask;
  end

  // assertions
  flag_set_a: assert property (@(posedge clock) disable iff (rst)
    mismatch |=> flag_reg) else $error("flag not set on mismatch");
  flag_hold_a: assert property (@(posedge clock) disable iff (rst)
    mismatch && wr_flag && !wb_dat_i[`CMP_FLAG_BIT] |=> flag_reg)
    else $error("mismatch lost to clear");
  snap_take_a: assert property (@(posedge clock) disable iff (rst)
    ctl_access |=> snap_reg == $past(sync2_reg)) else $error("no snapshot");
  irq_gate_a: assert property (@(posedge clock) disable iff (rst)
    irq |-> flag_reg && ie_reg && peripheral_irq_enable_reg && gie_reg) else $error("irq");
  result_ro_a: assert property (@(posedge clock) disable iff (rst)
    control_reg[7:6] == 2'b00) else $error("result bits written");
  result_rd_a: assert property (@(posedge clock) disable iff (rst)
    access && !wb_we_i && wb_adr_i == `CMP_CONTROL_IDX
    |=> rdata_reg[7:6] == $past(sync2_reg)) else $error("bad result");
  pol_flip_a: assert property (@(posedge clock) disable iff (rst)
    ##2 sync2_reg[0] == $past(cmp1_raw ^ control_reg[`CMP_CMP1_POLARITY_FLIP_BIT], 2))
    else $error("polarity");
  flag_clear_a: assert property (@(posedge clock) disable iff (rst)
    wr && wb_adr_i == `CMP_FLAG_IDX && !wb_dat_i[6] && !mismatch |=> !flag_reg)
    else $error("flag clear");
  out_mux_a: assert property (@(posedge clock) disable iff (rst)
    mode == cmp_ctl_pkg::mode_outputs |-> porta_pin_o[4] == live[1])
    else $error("pin4 mux");
  off_mode_a: assert property (@(posedge clock) disable iff (rst)
    mode == cmp_ctl_pkg::mode_off |-> !cmp1_enable) else $error("off");
  ack_one_a: assert property (@(posedge clock) disable iff (rst)
    ack_reg |=> !ack_reg) else $error("ack stuck");

  // routing, power, reset and comparator two polarity
  route_one_a: assert property (@(posedge clock) disable iff (rst)
    mode == cmp_ctl_pkg::mode_one_ind |-> cmp1_neg_sel_pin3 == control_reg[`CMP_CIS_BIT] &&
    !cmp2_neg_sel_pin2 && !ref_to_plus) else $error("mode one routing");
  route_four_a: assert property (@(posedge clock) disable iff (rst)
    mode == cmp_ctl_pkg::mode_four_ref |-> cmp1_neg_sel_pin3 == control_reg[`CMP_CIS_BIT] &&
    cmp2_neg_sel_pin2 == control_reg[`CMP_CIS_BIT]) else $error("mode two routing");
  ref_power_a: assert property (@(posedge clock) disable iff (rst)
    ref_to_plus |-> cmp1_enable && cmp2_enable)
    else $error("reference on idle comparators");
  power_down_a: assert property (@(posedge clock) disable iff (rst)
    mode == cmp_ctl_pkg::mode_reset |-> !cmp1_enable && !cmp2_enable)
    else $error("comparators on in reset mode");
  reset_ctl_a: assert property (@(posedge clock)
    rst |=> control_reg == `CMP_CONTROL_RESET && !ack_reg)
    else $error("control not cleared by reset");
  pol_flip2_a: assert property (@(posedge clock) disable iff (rst)
    ##2 sync2_reg[1] == $past(cmp2_raw ^ control_reg[`CMP_CMP2_POLARITY_FLIP_BIT], 2))
    else $error("comparator two polarity");

  // pins and port
  pin3_mux_a: assert property (@(posedge clock) disable iff (rst)
    mode == cmp_ctl_pkg::mode_outputs |-> porta_pin_o[3] == live[0])
    else $error("pin3 mux");
  pin_enable_a: assert property (@(posedge clock) disable iff (rst)
    mode == cmp_ctl_pkg::mode_outputs |-> porta_pin_oe[4:3] == ~dir_reg[4:3])
    else $error("pin enables lost");
  port_zero_a: assert property (@(posedge clock) disable iff (rst)
    access && !wb_we_i && wb_adr_i == `CMP_PORTA_IDX
    |=> (rdata_reg[4:0] & $past(analog_mask)) == 5'h00) else $error("analog pin read");

  // flag, snapshot and bus
  flag_write_a: assert property (@(posedge clock) disable iff (rst)
    wr_flag && wb_dat_i[`CMP_FLAG_BIT] |=> flag_reg)
    else $error("flag not set by write");
  irq_raise_a: assert property (@(posedge clock) disable iff (rst)
    flag_reg && ie_reg && peripheral_irq_enable_reg && gie_reg |-> irq)
    else $error("irq missing");
  snap_hold_a: assert property (@(posedge clock) disable iff (rst)
    !ctl_access |=> $stable(snap_reg))
    else $error("snapshot moved");
  ack_answer_a: assert property (@(posedge clock) disable iff (rst)
    access |=> ack_reg)
    else $error("no ack");
  data_idle_a: assert property (@(posedge clock) disable iff (rst)
    !ack_reg |-> wb_dat_o == 32'h0)
    else $error("read data outside ack");
  cover_irq_c: cover property (@(posedge clock) disable iff (rst) $rose(irq));
  cover_out_c: cover property (@(posedge clock) disable iff (rst)
    mode == cmp_ctl_pkg::mode_outputs && porta_pin_oe[3]);
  cover_clear_c: cover property (@(posedge clock) disable iff (rst) $fell(flag_reg));
  cover_miss_c: cover property (@(posedge clock) disable iff (rst)
    mismatch && ctl_access);
endmodule : dual_comparator_control

//--- dv/analog_front_model.sv
// behavioural model of the comparator inputs and port a pins
module analog_front_model (
  // clock
  input  wire logic       clock,
  // levels asked for by the bench
  input  wire logic       want1,
  input  wire logic       want2,
  input  wire logic [4:0] ext_level,
  // block side
  input  wire logic       cmp1_enable,
  input  wire logic       cmp2_enable,
  input  wire logic [4:0] porta_pin_o,
  input  wire logic [4:0] porta_pin_oe,
  output logic            cmp1_raw,
  output logic            cmp2_raw,
  output logic [4:0]      porta_pin_i
);
  timeunit 1ns;
  timeprecision 100ps;
  // powered-down comparator rests low
  always_ff @(posedge clock) begin
    cmp1_raw <= cmp1_enable & want1;
    cmp2_raw <= cmp2_enable & want2;
  end
  // driven pins win over the outside level
  assign porta_pin_i = (porta_pin_o & porta_pin_oe) | (ext_level & ~porta_pin_oe);
endmodule : analog_front_model

//--- dv/dual_comparator_control_test.sv
// self-checking bench of the comparator control block
module dual_comparator_control_test;
  timeunit 1ns;
  timeprecision 100ps;
  logic clock, rst, cyc, stb, we, want1, want2, irq, en1, en2, sel3, sel2, ref_plus, ack, err;
  logic [7:0]  adr;
  logic [31:0] wdat, rdat;
  logic [2:0]  mode;
  logic [4:0]  ext_level, pin_o, pin_oe, pin_i;
  logic        raw1, raw2;
  int          mismatches, checked;
  dual_comparator_control dut (.clock(clock), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .wb_err_o(err), .cmp1_raw(raw1), .cmp2_raw(raw2), .cmp_mode(mode),
    .cmp1_enable(en1), .cmp2_enable(en2), .cmp1_neg_sel_pin3(sel3),
    .cmp2_neg_sel_pin2(sel2), .ref_to_plus(ref_plus), .porta_pin_i(pin_i),
    .porta_pin_o(pin_o), .porta_pin_oe(pin_oe), .irq(irq));
  analog_front_model front (.clock(clock), .want1(want1), .want2(want2),
    .ext_level(ext_level), .cmp1_enable(en1), .cmp2_enable(en2), .porta_pin_o(pin_o),
    .porta_pin_oe(pin_oe), .cmp1_raw(raw1), .cmp2_raw(raw2), .porta_pin_i(pin_i));
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  task compare(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : compare
  task wb_cycle(input logic w, input logic [7:0] a, input logic [7:0] d,
                output logic [7:0] r);
    @(posedge clock);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h0, d};
    do begin
      @(posedge clock);
    end while (ack !== 1'b1);
    r = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask : wb_cycle
  task wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] r;
    wb_cycle(1'b1, a, d, r);
  endtask : wr
  task rd(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] r;
    wb_cycle(1'b0, a, 8'h00, r);
    compare(r, exp);
  endtask : rd
  task complete_run;
    $display("comparisons %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : complete_run
  initial begin
    #200000;
    mismatches++;
    complete_run;
  end
  initial begin
    rst = 1'b1;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    wdat = 32'h0;
    want1 = 1'b0;
    want2 = 1'b0;
    ext_level = 5'h1f;
    mismatches = 0;
    checked = 0;
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    rd(8'h1f, 8'h00);
    rd(8'h85, 8'hff);
    rd(8'h0c, 8'h00);
    compare({3'h0, pin_oe}, 8'h00);
    compare({7'h0, err}, 8'h00);
    $display("test reset done");
    for (int m = 0; m < 8; m++) begin
      wr(8'h1f, 8'hc0 | 8'(m));
      rd(8'h1f, 8'(m));
      compare({5'h0, mode}, 8'(m));
      compare({6'h0, en2, en1}, (m == 0 || m == 7) ? 8'h00 : 8'h03);
    end
    $display("test modes done");
    want1 <= 1'b1;
    wr(8'h1f, 8'h0a);
    repeat (4) @(posedge clock);
    rd(8'h1f, 8'h4a);
    compare({5'h0, ref_plus, sel2, sel3}, 8'h07);
    wr(8'h1f, 8'h3a);
    repeat (4) @(posedge clock);
    rd(8'h1f, 8'hba);
    wr(8'h1f, 8'h02);
    compare({6'h0, sel2, sel3}, 8'h00);
    wr(8'h1f, 8'h01);
    compare({6'h0, ref_plus, sel3}, 8'h00);
    wr(8'h1f, 8'h09);
    compare({7'h0, sel3}, 8'h01);
    $display("test routing done");
    repeat (4) @(posedge clock);
    rd(8'h1f, 8'h49);
    wr(8'h0c, 8'h00);
    rd(8'h0c, 8'h00);
    want1 <= 1'b0;
    repeat (4) @(posedge clock);
    rd(8'h0c, 8'h40);
    wr(8'h0c, 8'h00);
    rd(8'h0c, 8'h40);
    rd(8'h1f, 8'h09);
    wr(8'h0c, 8'h00);
    rd(8'h0c, 8'h00);
    wr(8'h0c, 8'h40);
    rd(8'h0c, 8'h40);
    for (int k = 0; k < 8; k++) begin
      wr(8'h8c, {1'b0, k[0], 6'h0});
      wr(8'h0b, {k[2], k[1], 6'h0});
      compare({7'h0, irq}, {7'h0, k == 7});
    end
    wr(8'h0c, 8'h00);
    compare({7'h0, irq}, 8'h00);
    $display("test flag done");
    wr(8'h8c, 8'h00);
    want1 <= 1'b1;
    wr(8'h1f, 8'h06);
    wr(8'h85, 8'h07);
    repeat (4) @(posedge clock);
    compare({3'h0, pin_o[4:3], pin_oe[4:3]}, 8'h07);
    wr(8'h05, 8'h1a);
    compare({3'h0, pin_o}, 8'h0a);
    wr(8'h85, 8'h1f);
    compare({6'h0, pin_oe[4:3]}, 8'h00);
    repeat (4) @(posedge clock);
    rd(8'h05, 8'h18);
    rd(8'h40, 8'h00);
    wr(8'h40, 8'hff);
    rd(8'h40, 8'h00);
    $display("test pins done");
    complete_run;
  end
endmodule : dual_comparator_control_test
